// ===== rtl/mii_route_pkg.sv
package mii_route_pkg;
   localparam logic [11:0] HARDWARE_CONFIGURATION_ADDR      = 12'h074;
   localparam logic [11:0] RX_SPACE_ADDR    = 12'h078;
   localparam int          CLK_SEL_LSB      = 5;
   localparam int          MGMT_SEL_BIT     = 4;
   localparam int          STRAP_BIT        = 3;
   localparam int          PORT_EN_BIT      = 2;
   localparam int          TX_ALLOC_LSB     = 16;
   localparam logic [1:0]  CLK_SEL_RESET    = 2'h0;
   localparam logic [3:0]  TX_ALLOC_RESET   = 4'h5;
   localparam logic [3:0]  TX_ALLOC_MAX     = 4'hE;
   localparam logic [15:0] TOTAL_BUF_BYTES  = 16'h4000;
   localparam logic [15:0] ALLOC_STEP_BYTES = 16'h0400;
   localparam int          STRAP_SETTLE_CYC = 3;
   typedef enum logic [1:0] {
      SRC_INT0,
      SRC_EXT,
      SRC_OFF,
      SRC_INT1
   } clk_src_t;
endpackage

// ===== rtl/sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_reg;
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         meta_reg <= '0;
         q        <= '0;
      end else begin
         meta_reg <= d;
         q        <= meta_reg;
      end
   end
endmodule
`default_nettype wire

// ===== rtl/mii_smi_source_select.sv
`timescale 1ns/1ps
`default_nettype none
module mii_smi_source_select
   import mii_route_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        rst_b,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Clocks from both PHYs
   input  wire logic        int_rx_clk,
   input  wire logic        int_tx_clk,
   input  wire logic        ext_rx_clk,
   input  wire logic        ext_tx_clk,
   output logic             mii_rx_clk,
   output logic             mii_tx_clk,
   // MAC side management port
   input  wire logic        mac_mdc,
   input  wire logic        mac_mdio_o,
   input  wire logic        mac_mdio_oe,
   output logic             mac_mdio_i,
   // Internal PHY management lines
   output logic             int_mdc,
   output logic             int_mdio_o,
   input  wire logic        int_mdio_i,
   // External PHY management pins
   output logic             ext_mdc,
   output logic             ext_mdio_o,
   output logic             ext_mdio_oe,
   input  wire logic        ext_mdio_i,
   // Data path routing and buffer split
   output logic             ext_port_en,
   output logic             int_phy_en,
   output logic      [15:0] rx_space_bytes
);
   // -------------------------------------------------------------
   // Input synchronisers
   // -------------------------------------------------------------
   logic [6:0] pin_s;
   sync2 #(.W(7)) u_sync (
      .mclk  (mclk),
      .rst_b (rst_b),
      .d     ({int_rx_clk, int_tx_clk, ext_rx_clk, ext_tx_clk,
               int_mdio_i, ext_mdio_i, 1'b0}),
      .q     (pin_s)
   );
   logic s_int_rx, s_int_tx, s_ext_rx, s_ext_tx, s_int_mdio, s_ext_mdio;
   assign s_int_rx   = pin_s[6];
   assign s_int_tx   = pin_s[5];
   assign s_ext_rx   = pin_s[4];
   assign s_ext_tx   = pin_s[3];
   assign s_int_mdio = pin_s[2];
   assign s_ext_mdio = pin_s[1];

   // -------------------------------------------------------------
   // Configuration register
   // -------------------------------------------------------------
   logic [1:0] clk_sel_reg;
   logic       mgmt_sel_reg;
   logic       port_en_reg;
   logic [3:0] tx_alloc_reg;
   logic       strap_reg;
   logic [2:0] settle_reg;
   logic       wr_en;
   logic       acc;

   assign acc   = psel && penable;
   assign wr_en = acc && pwrite && (paddr == HARDWARE_CONFIGURATION_ADDR);

   function automatic logic [3:0] clamp_alloc(input logic [3:0] v);
      clamp_alloc = (v > TX_ALLOC_MAX) ? TX_ALLOC_MAX : v;
   endfunction

   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         clk_sel_reg  <= CLK_SEL_RESET;
         mgmt_sel_reg <= 1'b0;
         port_en_reg  <= 1'b0;
         tx_alloc_reg <= TX_ALLOC_RESET;
      end else if (wr_en) begin
         // Each field written on its own, no cross coupling
         clk_sel_reg  <= pwdata[CLK_SEL_LSB +: 2];
         mgmt_sel_reg <= pwdata[MGMT_SEL_BIT];
         port_en_reg  <= pwdata[PORT_EN_BIT];
         tx_alloc_reg <= clamp_alloc(pwdata[TX_ALLOC_LSB +: 4]);
      end
   end

   // -------------------------------------------------------------
   // Strap capture
   // -------------------------------------------------------------
   // Sampled once the synchroniser has filled after release; the
   // external MDIO is not driven by us while reset holds the target bit 0
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         settle_reg <= 3'h0;
         strap_reg  <= 1'b0;
      end else if (settle_reg != 3'(STRAP_SETTLE_CYC)) begin
         settle_reg <= settle_reg + 3'h1;
         if (settle_reg == 3'(STRAP_SETTLE_CYC - 1)) begin
            strap_reg <= s_ext_mdio;
         end
      end
   end

   // -------------------------------------------------------------
   // APB read side
   // -------------------------------------------------------------
   logic [31:0] rd_word;
   always_comb begin
      rd_word = 32'h0;
      if (paddr == HARDWARE_CONFIGURATION_ADDR) begin
         rd_word[TX_ALLOC_LSB +: 4] = tx_alloc_reg;
         rd_word[CLK_SEL_LSB +: 2]  = clk_sel_reg;
         rd_word[MGMT_SEL_BIT]      = mgmt_sel_reg;
         rd_word[STRAP_BIT]         = strap_reg;
         rd_word[PORT_EN_BIT]       = port_en_reg;
      end else if (paddr == RX_SPACE_ADDR) begin
         rd_word[15:0] = rx_space_bytes;
      end
   end

   // No wait states; prdata is a flop loaded in the setup cycle
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         pready  <= 1'b0;
         prdata  <= 32'h0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable
                    && paddr != HARDWARE_CONFIGURATION_ADDR && paddr != RX_SPACE_ADDR;
         if (psel && !penable && !pwrite) begin
            prdata <= rd_word;
         end
      end
   end

   // -------------------------------------------------------------
   // Receive buffer space
   // -------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         rx_space_bytes <= TOTAL_BUF_BYTES - 16'(TX_ALLOC_RESET) * ALLOC_STEP_BYTES;
      end else begin
         rx_space_bytes <= TOTAL_BUF_BYTES - 16'(tx_alloc_reg) * ALLOC_STEP_BYTES;
      end
   end

   // -------------------------------------------------------------
   // Clock routing
   // -------------------------------------------------------------
   // Clocks are resampled on mclk; fine for a 6.25 MHz link, not jitter free
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         mii_rx_clk <= 1'b0;
         mii_tx_clk <= 1'b0;
      end else begin
         case (clk_src_t'(clk_sel_reg))
            SRC_EXT: begin
               mii_rx_clk <= s_ext_rx;
               mii_tx_clk <= s_ext_tx;
            end
            SRC_OFF: begin
               mii_rx_clk <= 1'b0;
               mii_tx_clk <= 1'b0;
            end
            default: begin
               mii_rx_clk <= s_int_rx;
               mii_tx_clk <= s_int_tx;
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // Management routing
   // -------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         int_mdc     <= 1'b0;
         int_mdio_o  <= 1'b0;
         ext_mdc     <= 1'b0;
         ext_mdio_o  <= 1'b0;
         ext_mdio_oe <= 1'b0;
         mac_mdio_i  <= 1'b0;
      end else if (mgmt_sel_reg) begin
         int_mdc     <= 1'b0;
         int_mdio_o  <= 1'b0;
         ext_mdc     <= mac_mdc;
         ext_mdio_o  <= mac_mdio_o;
         ext_mdio_oe <= mac_mdio_oe;
         mac_mdio_i  <= mac_mdio_oe ? mac_mdio_o : s_ext_mdio;
      end else begin
         int_mdc     <= mac_mdc;
         int_mdio_o  <= mac_mdio_oe ? mac_mdio_o : 1'b1;
         ext_mdc     <= 1'b0;
         ext_mdio_o  <= 1'b0;
         ext_mdio_oe <= 1'b0;
         mac_mdio_i  <= mac_mdio_oe ? mac_mdio_o : s_int_mdio;
      end
   end

   // -------------------------------------------------------------
   // Data path enable
   // -------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ext_port_en <= 1'b0;
         int_phy_en  <= 1'b1;
      end else begin
         ext_port_en <= port_en_reg;
         int_phy_en  <= !port_en_reg;
      end
   end
endmodule
`default_nettype wire

// ===== verif/mii_route_chk.sv
`timescale 1ns/1ps
`default_nettype none
module mii_route_chk
   import mii_route_pkg::*;
(
   input wire logic        mclk,
   input wire logic        rst_b,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        mac_mdc,
   input wire logic        mii_rx_clk,
   input wire logic        mii_tx_clk,
   input wire logic        int_mdc,
   input wire logic        int_mdio_o,
   input wire logic        ext_mdc,
   input wire logic        ext_mdio_oe,
   input wire logic        ext_port_en,
   input wire logic        int_phy_en,
   input wire logic [15:0] rx_space_bytes
);
   logic       sel_q;
   logic       pe_q;
   logic [1:0] clk_q;
   logic [3:0] alloc_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // ----
   // Shadow fields, taken at the write's access edge
   // ----
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         sel_q   <= 1'h0;
         pe_q    <= 1'h0;
         clk_q   <= CLK_SEL_RESET;
         alloc_q <= TX_ALLOC_RESET;
      end else if (psel && penable && pready && pwrite && paddr == HARDWARE_CONFIGURATION_ADDR) begin
         sel_q   <= pwdata[MGMT_SEL_BIT];
         pe_q    <= pwdata[PORT_EN_BIT];
         clk_q   <= pwdata[6:5];
         alloc_q <= (pwdata[19:16] > TX_ALLOC_MAX) ? TX_ALLOC_MAX : pwdata[19:16];
      end
   end
   a_int_held_low: assert property (sel_q && $past(sel_q) && $past(rst_b) |-> !int_mdc && !int_mdio_o)
      else $error("internal management lines not low");
   a_ext_released: assert property (!sel_q && !$past(sel_q) |-> !ext_mdio_oe && !ext_mdc)
      else $error("external management pins not idle");
   a_ext_follows: assert property (sel_q && $past(sel_q) && $past(rst_b) |-> ext_mdc == $past(mac_mdc))
      else $error("external clock line not following");
   a_int_follows: assert property (!sel_q && !$past(sel_q) && $past(rst_b) |-> int_mdc == $past(mac_mdc))
      else $error("internal clock line not following");
   a_rx_space_ok: assert property (alloc_q == $past(alloc_q) && $past(rst_b)
      |-> rx_space_bytes == TOTAL_BUF_BYTES - ALLOC_STEP_BYTES * alloc_q)
      else $error("receive space wrong");
   a_port_enable: assert property (pe_q == $past(pe_q) && $past(rst_b) |-> ext_port_en == pe_q && int_phy_en == !pe_q)
      else $error("port enable outputs wrong");
   a_clocks_off: assert property ((clk_q == 2'h2) [*6] |-> !mii_rx_clk && !mii_tx_clk)
      else $error("clocks not stopped");
   a_unmapped_err: assert property (psel && penable && pready && paddr != HARDWARE_CONFIGURATION_ADDR && paddr != RX_SPACE_ADDR
      |-> pslverr)
      else $error("unmapped access not refused");
endmodule
bind mii_smi_source_select mii_route_chk u_chk (.*);
`default_nettype wire

// ===== verif/phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module phy_model #(
   parameter int INT_HALF_NS = 240,
   parameter int EXT_HALF_NS = 80
) (
   input  wire logic pull_lvl,
   input  wire logic int_mdc,
   input  wire logic ext_mdio_o,
   input  wire logic ext_mdio_oe,
   output logic      int_rx_clk,
   output logic      int_tx_clk,
   output logic      ext_rx_clk,
   output logic      ext_tx_clk,
   output logic      int_mdio_i,
   output logic      ext_mdio_i
);
   // MII clocks run free; the rates differ so the bench can tell them apart
   initial begin
      int_rx_clk = 1'h0;
      forever #(INT_HALF_NS) int_rx_clk = ~int_rx_clk;
   end
   initial begin
      ext_rx_clk = 1'h0;
      #37;
      forever #(EXT_HALF_NS) ext_rx_clk = ~ext_rx_clk;
   end
   assign int_tx_clk = ~int_rx_clk;
   assign ext_tx_clk = ~ext_rx_clk;
   assign int_mdio_i = ~int_mdc;
   // Released pin settles to the board strap level
   assign ext_mdio_i = ext_mdio_oe ? ext_mdio_o : pull_lvl;
endmodule
`default_nettype wire

// ===== verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import mii_route_pkg::*;
   logic        mclk, rst_b, psel, penable, pwrite, mac_mdc, mac_mdio_o, mac_mdio_oe, pull_lvl, er, prv_r, prv_t;
   logic        pready, pslverr, mii_rx_clk, mii_tx_clk, mac_mdio_i, int_mdc, int_mdio_o, int_mdio_i;
   logic        ext_mdc, ext_mdio_o, ext_mdio_oe, ext_mdio_i, ext_port_en, int_phy_en;
   logic        int_rx_clk, int_tx_clk, ext_rx_clk, ext_tx_clk;
   logic [3:0]  kb, a;
   logic [11:0] paddr;
   logic [15:0] rx_space_bytes;
   logic [31:0] pwdata, prdata, rd, ex;
   int          n_fail, cmp_count, cyc, cr, ct;
   mii_smi_source_select dut (.*);
   phy_model u_phy (.*);
   initial begin
      mclk = 1'h0;
      forever #10 mclk = ~mclk;
   end
   // ----
   // Access and check tasks
   // ----
   task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] wd);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= ad;
      pwdata <= wd;
      @(posedge mclk);
      penable <= 1'h1;
      // Only the hang guard ends a wait for the answer
      do begin
         @(posedge mclk);
      end while (pready !== 1'h1);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge mclk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic results;
      $display("compares %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   function automatic logic [31:0] cat(input int n);
      return (n == 0) ? 32'h0 : (n > 7) ? 32'h1 : 32'h2;
   endfunction
   // Hang guard: the whole run needs under 3000 cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_fail++;
         results();
      end
   end
   task automatic restart(input logic lvl);
      rst_b <= 1'h0;
      pull_lvl <= lvl;
      repeat (6) @(posedge mclk);
      rst_b <= 1'h1;
      repeat (8) @(posedge mclk);
   endtask
   initial begin
      {psel, penable, pwrite, mac_mdc, mac_mdio_o, mac_mdio_oe} = 6'h0;
      paddr = 12'h0;
      pwdata = 32'h0;
      rst_b = 1'h0;
      pull_lvl = 1'h1;
      @(posedge mclk);
      restart(1'h1);
      apb(1'h0, HARDWARE_CONFIGURATION_ADDR, 32'h0);
      chk(rd, 32'h0005_0008);
      apb(1'h0, RX_SPACE_ADDR, 32'h0);
      chk(rd, 32'h0000_2C00);
      mac_mdc <= 1'h1;
      for (int k = 0; k < 16; k++) begin
         kb = k[3:0];
         a = (kb > 4'hE) ? 4'hE : kb;
         apb(1'h1, HARDWARE_CONFIGURATION_ADDR, {12'h0, kb, 9'h1FF, kb[1:0], kb[2], 1'h0, kb[3], 2'h3});
         ex = {12'h0, a, 9'h0, kb[1:0], kb[2], 1'h1, kb[3], 2'h0};
         apb(1'h0, HARDWARE_CONFIGURATION_ADDR, 32'h0);
         chk(rd, ex);
         apb(1'h0, RX_SPACE_ADDR, 32'h0);
         chk(rd, {16'h0, TOTAL_BUF_BYTES - ALLOC_STEP_BYTES * a});
         repeat (8) @(posedge mclk);
         chk({31'h0, mac_mdio_i}, {31'h0, kb[2]});
         chk({30'h0, ext_port_en, int_phy_en}, {30'h0, kb[3], !kb[3]});
         cr = 0;
         ct = 0;
         prv_r = mii_rx_clk;
         prv_t = mii_tx_clk;
         repeat (48) begin
            @(posedge mclk);
            cr += int'(mii_rx_clk !== prv_r);
            ct += int'(mii_tx_clk !== prv_t);
            prv_r = mii_rx_clk;
            prv_t = mii_tx_clk;
         end
         chk(cat(cr), (kb[1:0] == 2'h1) ? 32'h1 : (kb[1:0] == 2'h2) ? 32'h0 : 32'h2);
         chk(cat(ct), (kb[1:0] == 2'h1) ? 32'h1 : (kb[1:0] == 2'h2) ? 32'h0 : 32'h2);
      end
      apb(1'h1, 12'h07C, 32'hFFFF_FFFF);
      chk({31'h0, er}, 32'h1);
      apb(1'h1, RX_SPACE_ADDR, 32'h0);
      apb(1'h0, RX_SPACE_ADDR, 32'h0);
      chk(rd, 32'h0000_0800);
      apb(1'h0, HARDWARE_CONFIGURATION_ADDR, 32'h0);
      chk(rd, ex);
      mac_mdio_oe <= 1'h1;
      mac_mdio_o <= 1'h1;
      repeat (4) @(posedge mclk);
      chk({28'h0, ext_mdio_oe, ext_mdio_o, int_mdio_o, mac_mdio_i}, 32'hD);
      restart(1'h0);
      apb(1'h0, HARDWARE_CONFIGURATION_ADDR, 32'h0);
      chk(rd, 32'h0005_0000);
      results();
   end
endmodule
`default_nettype wire
